// ### logic/pcr_regs.sv
`include "pcr_map.svh"

// Functional notes
// - LDO1 flag set only when below target, enabled
// - Fault mask at 02h, resets C0h on lockout
// - Mask bit one keeps its flag off interrupt
// - Supply on needs enable bit and pin high
// - Lockout sets supply enable register to FFh
// - Low enable pin forces its enable bit one
// - Enable bits 5..1; LDO pin restores both LDOs
// - Converter control at 04h, resets B1h, writable
// - Phase codes for buck2 and buck3 delays
// - Bit 3 selects low ripple PFM mode
// - Bits 2,1,0 force fixed frequency PWM
// - Second control at 05h resets 40h, 5:3 unused
// - Writing one to bit 7 starts core change
// - Trigger clears when code reaches target
// - Bit 6 selects pin or register core voltage
// - Discharge bits discharge disabled converter outputs
// - Core code at 06h, default follows select pin
// - Core code restored on five reset events
// - Interrupt pin combines all power good flags
// - Status read blocks its active flags from interrupt
module pcr_regs #(
  parameter logic [7:0] VERSION_CODE = 8'h5a  // Arbitrary value.
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic              i_wr_stb,
  input  wire logic              i_rd_stb,
  input  wire logic [7:0]        i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_undervoltage_lockout,
  input  wire logic              i_buck1_enable_pin,
  input  wire logic              i_buck2_enable_pin,
  input  wire logic              i_buck3_enable_pin,
  input  wire logic              i_ldo_enable_pin,
  input  wire logic              i_core_default_select_pin,
  input  wire logic              i_warm_reset_input_n,
  input  wire logic              i_power_on_reset_out,
  input  wire logic              i_rtc_supply_low,
  input  wire logic              i_power_fail_flag,
  input  wire logic              i_low_battery_flag,
  input  wire logic [4:0]        i_below_target,
  input  wire logic [2:0]        i_core_slew_setting,
  output logic [7:0]             o_rdata,
  output logic                   o_rd_valid,
  output logic                   o_int_n,
  output logic                   o_buck1_on,
  output logic                   o_buck2_on,
  output logic                   o_buck3_on,
  output logic                   o_ldo2_on,
  output logic                   o_ldo1_on,
  output logic [1:0]             o_buck2_phase,
  output logic [1:0]             o_buck3_phase,
  output logic                   o_low_ripple,
  output logic                   o_buck1_forced_fixed_freq,
  output logic                   o_buck2_forced_fixed_freq,
  output logic                   o_buck3_forced_fixed_freq,
  output logic                   o_buck1_discharge,
  output logic                   o_buck2_discharge,
  output logic                   o_buck3_discharge,
  output logic                   o_core_use_pin,
  output pcr_pkg::pcr_code_t     o_core_voltage_code
);

  pcr_pkg::pcr_byte_t fault_mask;
  pcr_pkg::pcr_byte_t supply_enable;
  pcr_pkg::pcr_byte_t converter_ctrl_reg;
  pcr_pkg::pcr_byte_t converter_ctrl_second;
  pcr_pkg::pcr_code_t core_voltage_code;
  pcr_pkg::pcr_byte_t supply_fault_flags;
  pcr_pkg::pcr_byte_t blocked;
  pcr_pkg::pcr_byte_t next_flags;
  pcr_pkg::pcr_byte_t pin_low;
  pcr_pkg::pcr_code_t default_code;
  logic               core_moving;
  logic               core_done;
  logic               core_reset_event;
  logic               wr_mask;
  logic               wr_enable;
  logic               wr_ctrl;
  logic               wr_second;
  logic               wr_core;
  logic               rd_flags;

  // Default core code: bits 3 and 1 follow the select pin (14h or 1Eh).
  function automatic pcr_pkg::pcr_code_t core_default(input logic sel);
    core_default = {1'b1, sel, 1'b1, sel, 1'b0};
  endfunction

  assign default_code = core_default(i_core_default_select_pin);

  assign wr_mask   = i_wr_stb && (i_addr == `PCR_ADDR_FAULT_MASK);
  assign wr_enable = i_wr_stb && (i_addr == `PCR_ADDR_SUPPLY_ENABLE);
  assign wr_ctrl   = i_wr_stb && (i_addr == `PCR_ADDR_CONV_CTRL);
  assign wr_second = i_wr_stb && (i_addr == `PCR_ADDR_CONV_SECOND);
  assign wr_core   = i_wr_stb && (i_addr == `PCR_ADDR_CORE_TARGET);
  assign rd_flags  = i_rd_stb && (i_addr == `PCR_ADDR_FAULT_FLAGS);

  // Enable pins mapped onto their register bit positions; the LDO pin serves both LDOs.
  assign pin_low = {2'b00,
                    ~i_buck1_enable_pin,
                    ~i_buck2_enable_pin,
                    ~i_buck3_enable_pin,
                    ~i_ldo_enable_pin,
                    ~i_ldo_enable_pin,
                    1'b0};

  assign core_reset_event = i_undervoltage_lockout
                         || (!o_buck1_on && !o_buck3_on)
                         || !i_warm_reset_input_n
                         || i_power_on_reset_out
                         || i_rtc_supply_low;

  // Fault flags read zero for a disabled supply and for buck3 while its code moves.
  always_comb begin
    next_flags    = 8'h00;
    next_flags[7] = i_power_fail_flag;
    next_flags[6] = i_low_battery_flag;
    next_flags[5] = i_below_target[4] && o_buck1_on;
    next_flags[4] = i_below_target[3] && o_buck2_on;
    next_flags[3] = i_below_target[2] && o_buck3_on && !core_moving;
    next_flags[2] = i_below_target[1] && o_ldo2_on;
    next_flags[1] = i_below_target[0] && o_ldo1_on;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || i_undervoltage_lockout) begin
      fault_mask <= `PCR_RST_FAULT_MASK;
    end else if (wr_mask) begin
      fault_mask <= i_wdata & `PCR_MASK_WRITABLE;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || i_undervoltage_lockout) begin
      supply_enable <= `PCR_RST_SUPPLY_ENABLE;
    end else begin
      // A low pin wins over a host write to the same bit.
      if (wr_enable) begin
        supply_enable <= (i_wdata & `PCR_EN_WRITABLE) | ~`PCR_EN_WRITABLE | pin_low;
      end else begin
        supply_enable <= supply_enable | pin_low;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || i_undervoltage_lockout) begin
      converter_ctrl_reg <= `PCR_RST_CONV_CTRL;
    end else if (wr_ctrl) begin
      converter_ctrl_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || i_undervoltage_lockout) begin
      converter_ctrl_second <= `PCR_RST_CONV_SECOND;
    end else begin
      if (wr_second) begin
        converter_ctrl_second[`PCR_C2_USE_PIN]  <= i_wdata[`PCR_C2_USE_PIN];
        converter_ctrl_second[`PCR_C2_DIS_BUCK2] <= i_wdata[`PCR_C2_DIS_BUCK2];
        converter_ctrl_second[`PCR_C2_DIS_BUCK1] <= i_wdata[`PCR_C2_DIS_BUCK1];
        converter_ctrl_second[`PCR_C2_DIS_BUCK3] <= i_wdata[`PCR_C2_DIS_BUCK3];
      end
      // A new start written in the completion cycle wins over the clear.
      if (wr_second && i_wdata[`PCR_C2_GO]) begin
        converter_ctrl_second[`PCR_C2_GO] <= 1'b1;
      end else if (core_done) begin
        converter_ctrl_second[`PCR_C2_GO] <= 1'b0;
      end
      converter_ctrl_second[5:3] <= 3'b000;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || core_reset_event) begin
      core_voltage_code <= i_rst ? `PCR_RST_CORE_CODE : default_code;
    end else if (wr_core) begin
      core_voltage_code <= i_wdata[4:0];
    end
  end

  // Flags seen by a status read stay off the interrupt pin until they drop.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      supply_fault_flags <= 8'h00;
      blocked            <= 8'h00;
      o_int_n            <= 1'b1;
    end else begin
      supply_fault_flags <= next_flags;
      blocked            <= (blocked & next_flags)
                          | (rd_flags ? (supply_fault_flags & next_flags) : 8'h00);
      o_int_n <= ~|(supply_fault_flags & ~fault_mask & ~blocked);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata    <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_stb;
      if (i_rd_stb) begin
        case (i_addr)
          `PCR_ADDR_VERSION:       o_rdata <= VERSION_CODE;
          `PCR_ADDR_FAULT_FLAGS:   o_rdata <= supply_fault_flags;
          `PCR_ADDR_FAULT_MASK:    o_rdata <= fault_mask;
          `PCR_ADDR_SUPPLY_ENABLE: o_rdata <= supply_enable;
          `PCR_ADDR_CONV_CTRL:     o_rdata <= converter_ctrl_reg;
          `PCR_ADDR_CONV_SECOND:   o_rdata <= converter_ctrl_second;
          `PCR_ADDR_CORE_TARGET:   o_rdata <= {3'b000, core_voltage_code};
          default:                 o_rdata <= `PCR_UNMAPPED_READ;
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_buck1_on <= 1'b0;
      o_buck2_on <= 1'b0;
      o_buck3_on <= 1'b0;
      o_ldo2_on  <= 1'b0;
      o_ldo1_on  <= 1'b0;
    end else begin
      o_buck1_on <= supply_enable[`PCR_EN_BUCK1] && i_buck1_enable_pin;
      o_buck2_on <= supply_enable[`PCR_EN_BUCK2] && i_buck2_enable_pin;
      o_buck3_on <= supply_enable[`PCR_EN_BUCK3] && i_buck3_enable_pin;
      o_ldo2_on  <= supply_enable[`PCR_EN_LDO2] && i_ldo_enable_pin;
      o_ldo1_on  <= supply_enable[`PCR_EN_LDO1] && i_ldo_enable_pin;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_buck2_phase             <= 2'b00;
      o_buck3_phase             <= 2'b00;
      o_low_ripple              <= 1'b0;
      o_buck1_forced_fixed_freq <= 1'b0;
      o_buck2_forced_fixed_freq <= 1'b0;
      o_buck3_forced_fixed_freq <= 1'b0;
    end else begin
      o_buck2_phase             <= converter_ctrl_reg[7:6];
      o_buck3_phase             <= converter_ctrl_reg[5:4];
      o_low_ripple              <= converter_ctrl_reg[`PCR_CC_LOW_RIPPLE];
      o_buck2_forced_fixed_freq <= converter_ctrl_reg[`PCR_CC_FORCED_FIXED_FREQ_BUCK2];
      o_buck1_forced_fixed_freq <= converter_ctrl_reg[`PCR_CC_FORCED_FIXED_FREQ_BUCK1];
      o_buck3_forced_fixed_freq <= converter_ctrl_reg[`PCR_CC_FORCED_FIXED_FREQ_BUCK3];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_buck1_discharge <= 1'b0;
      o_buck2_discharge <= 1'b0;
      o_buck3_discharge <= 1'b0;
      o_core_use_pin    <= 1'b1;
    end else begin
      o_buck2_discharge <= converter_ctrl_second[`PCR_C2_DIS_BUCK2] && !o_buck2_on;
      o_buck1_discharge <= converter_ctrl_second[`PCR_C2_DIS_BUCK1] && !o_buck1_on;
      o_buck3_discharge <= converter_ctrl_second[`PCR_C2_DIS_BUCK3] && !o_buck3_on;
      o_core_use_pin    <= converter_ctrl_second[`PCR_C2_USE_PIN];
    end
  end

  pcr_core_ramp u_ramp (
    .i_mclk         (i_mclk),
    .i_rst          (i_rst),
    .i_load_default (core_reset_event),
    .i_default_code (default_code),
    .i_go           (converter_ctrl_second[`PCR_C2_GO]),
    .i_target       (core_voltage_code),
    .i_slew         (i_core_slew_setting),
    .o_code         (o_core_voltage_code),
    .o_moving       (core_moving),
    .o_done         (core_done)
  );

  property p_lockout_defaults;
    @(posedge i_mclk) disable iff (i_rst)
    i_undervoltage_lockout |=> (fault_mask == `PCR_RST_FAULT_MASK)
                            && (supply_enable == `PCR_RST_SUPPLY_ENABLE)
                            && (converter_ctrl_reg == `PCR_RST_CONV_CTRL);
  endproperty
  a_lockout_defaults: assert property (p_lockout_defaults)
    else $error("lockout did not restore register defaults");

  property p_supply_and;
    @(posedge i_mclk) disable iff (i_rst)
    (supply_enable[`PCR_EN_BUCK1] && i_buck1_enable_pin) |=> o_buck1_on;
  endproperty
  a_supply_and: assert property (p_supply_and)
    else $error("buck1 not on with bit and pin high");

  property p_pin_off;
    @(posedge i_mclk) disable iff (i_rst)
    !i_ldo_enable_pin |=> !o_ldo1_on && !o_ldo2_on
                       && supply_enable[`PCR_EN_LDO1] && supply_enable[`PCR_EN_LDO2];
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("low LDO pin did not force bits and turn LDOs off");

  property p_masked_quiet;
    @(posedge i_mclk) disable iff (i_rst)
    ((supply_fault_flags & ~fault_mask & ~blocked) == 8'h00) |=> o_int_n;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("masked flag reached interrupt pin");

  property p_read_blocks;
    @(posedge i_mclk) disable iff (i_rst)
    (rd_flags && supply_fault_flags[1] && next_flags[1]) |=> blocked[1];
  endproperty
  a_read_blocks: assert property (p_read_blocks)
    else $error("status read did not block active flag");

  property p_ldo1_flag;
    @(posedge i_mclk) disable iff (i_rst)
    !o_ldo1_on |=> !supply_fault_flags[1];
  endproperty
  a_ldo1_flag: assert property (p_ldo1_flag)
    else $error("LDO1 flag set while LDO1 disabled");

  property p_go_set;
    @(posedge i_mclk) disable iff (i_rst || i_undervoltage_lockout)
    (wr_second && i_wdata[`PCR_C2_GO]) |=> converter_ctrl_second[`PCR_C2_GO];
  endproperty
  a_go_set: assert property (p_go_set)
    else $error("start bit not set by write");

  property p_go_clear;
    @(posedge i_mclk) disable iff (i_rst)
    (core_done && !(wr_second && i_wdata[`PCR_C2_GO]))
      |=> !converter_ctrl_second[`PCR_C2_GO]
          && ((o_core_voltage_code == $past(core_voltage_code)) || $past(core_reset_event));
  endproperty
  a_go_clear: assert property (p_go_clear)
    else $error("start bit not cleared at code match");

  property p_warm_reset;
    @(posedge i_mclk) disable iff (i_rst)
    !i_warm_reset_input_n |=> (core_voltage_code == $past(default_code))
                           && (o_core_voltage_code == $past(default_code));
  endproperty
  a_warm_reset: assert property (p_warm_reset)
    else $error("core code not restored on warm reset");

  property p_discharge;
    @(posedge i_mclk) disable iff (i_rst)
    (converter_ctrl_second[`PCR_C2_DIS_BUCK3] && !o_buck3_on) |=> o_buck3_discharge;
  endproperty
  a_discharge: assert property (p_discharge)
    else $error("buck3 not discharged while disabled");

  property p_unused_zero;
    @(posedge i_mclk) disable iff (i_rst)
    1'b1 |=> (converter_ctrl_second[5:3] == 3'b000) && (fault_mask[0] == 1'b0);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused bit not zero");

endmodule

// ### common/pcr_map.svh
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

// Register offsets on the internal register port.
`define PCR_ADDR_VERSION        8'h00
`define PCR_ADDR_FAULT_FLAGS    8'h01
`define PCR_ADDR_FAULT_MASK     8'h02
`define PCR_ADDR_SUPPLY_ENABLE  8'h03
`define PCR_ADDR_CONV_CTRL      8'h04
`define PCR_ADDR_CONV_SECOND    8'h05
`define PCR_ADDR_CORE_TARGET    8'h06

// Reset values.
`define PCR_RST_FAULT_MASK      8'hc0
`define PCR_RST_SUPPLY_ENABLE   8'hff
`define PCR_RST_CONV_CTRL       8'hb1
`define PCR_RST_CONV_SECOND     8'h40
`define PCR_RST_CORE_CODE       5'h14
`define PCR_UNMAPPED_READ       8'hff

// Field positions.
`define PCR_EN_BUCK1            5
`define PCR_EN_BUCK2            4
`define PCR_EN_BUCK3            3
`define PCR_EN_LDO2             2
`define PCR_EN_LDO1             1
`define PCR_EN_WRITABLE         8'h3e
`define PCR_MASK_WRITABLE       8'hfe
`define PCR_FLAG_BUCK3          3
`define PCR_CC_LOW_RIPPLE       3
`define PCR_CC_FORCED_FIXED_FREQ_BUCK2       2
`define PCR_CC_FORCED_FIXED_FREQ_BUCK1       1
`define PCR_CC_FORCED_FIXED_FREQ_BUCK3       0
`define PCR_C2_GO               7
`define PCR_C2_USE_PIN          6
`define PCR_C2_DIS_BUCK2        2
`define PCR_C2_DIS_BUCK1        1
`define PCR_C2_DIS_BUCK3        0
`define PCR_C2_WRITABLE         8'h47

// Core code stepping: one code step is 25 mV, rates in uV per us.
`define PCR_CLK_MHZ             10
`define PCR_STEP_UV             25000
`define PCR_RATE0_UVUS          150
`define PCR_RATE1_UVUS          300
`define PCR_RATE2_UVUS          600
`define PCR_RATE3_UVUS          1200
`define PCR_RATE4_UVUS          2400
`define PCR_RATE5_UVUS          4800
`define PCR_RATE6_UVUS          9600
`define PCR_SLEW_IMMEDIATE      3'h7

`endif

// ### common/pcr_pkg.sv
package pcr_pkg;

  typedef logic [7:0] pcr_byte_t;
  typedef logic [4:0] pcr_code_t;

  typedef enum logic {
    PCR_RAMP_IDLE = 1'b0,
    PCR_RAMP_MOVE = 1'b1
  } pcr_ramp_state_t;

endpackage

// ### logic/pcr_core_ramp.sv
`include "pcr_map.svh"

module pcr_core_ramp (
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic              i_load_default,
  input  wire pcr_pkg::pcr_code_t i_default_code,
  input  wire logic              i_go,
  input  wire pcr_pkg::pcr_code_t i_target,
  input  wire logic [2:0]        i_slew,
  output pcr_pkg::pcr_code_t     o_code,
  output logic                   o_moving,
  output logic                   o_done
);

  pcr_pkg::pcr_ramp_state_t state;
  logic [10:0]              wait_cnt;

  // Cycles between two code steps for each slew setting, rounded down.
  function automatic logic [10:0] step_cycles(input logic [2:0] slew);
    case (slew)
      3'h0:    step_cycles = 11'(`PCR_STEP_UV * `PCR_CLK_MHZ / `PCR_RATE0_UVUS);
      3'h1:    step_cycles = 11'(`PCR_STEP_UV * `PCR_CLK_MHZ / `PCR_RATE1_UVUS);
      3'h2:    step_cycles = 11'(`PCR_STEP_UV * `PCR_CLK_MHZ / `PCR_RATE2_UVUS);
      3'h3:    step_cycles = 11'(`PCR_STEP_UV * `PCR_CLK_MHZ / `PCR_RATE3_UVUS);
      3'h4:    step_cycles = 11'(`PCR_STEP_UV * `PCR_CLK_MHZ / `PCR_RATE4_UVUS);
      3'h5:    step_cycles = 11'(`PCR_STEP_UV * `PCR_CLK_MHZ / `PCR_RATE5_UVUS);
      3'h6:    step_cycles = 11'(`PCR_STEP_UV * `PCR_CLK_MHZ / `PCR_RATE6_UVUS);
      default: step_cycles = 11'h000;
    endcase
  endfunction

  // Done means the code has reached the target, not that the output has settled.
  assign o_done   = (state == pcr_pkg::PCR_RAMP_MOVE) && (o_code == i_target);
  assign o_moving = (state == pcr_pkg::PCR_RAMP_MOVE);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state    <= pcr_pkg::PCR_RAMP_IDLE;
      o_code   <= `PCR_RST_CORE_CODE;
      wait_cnt <= 11'h000;
    end else if (i_load_default) begin
      state    <= pcr_pkg::PCR_RAMP_IDLE;
      o_code   <= i_default_code;
      wait_cnt <= 11'h000;
    end else begin
      unique case (state)
        pcr_pkg::PCR_RAMP_IDLE: begin
          if (i_go) begin
            state    <= pcr_pkg::PCR_RAMP_MOVE;
            wait_cnt <= step_cycles(i_slew);
          end
        end
        pcr_pkg::PCR_RAMP_MOVE: begin
          if (o_code == i_target) begin
            state <= pcr_pkg::PCR_RAMP_IDLE;
          end else if (i_slew == `PCR_SLEW_IMMEDIATE) begin
            o_code <= i_target;
          end else if (wait_cnt == 11'h000) begin
            o_code   <= (o_code < i_target) ? o_code + 5'h01 : o_code - 5'h01;
            wait_cnt <= step_cycles(i_slew);
          end else begin
            wait_cnt <= wait_cnt - 11'h001;
          end
        end
      endcase
    end
  end

endmodule

// ### tb/pcr_host.sv
module pcr_host (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rd_valid,
  output logic            o_wr_stb,
  output logic            o_rd_stb,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_addr   = 8'h00;
    o_wdata  = 8'h00;
  end

  // Released lines show the inverse of their last value, so stale data never looks valid.
  task automatic release_bus();
    o_addr  = ~o_addr;
    o_wdata = ~o_wdata;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    #1;
    o_wr_stb = 1'b1;
    o_addr   = a;
    o_wdata  = d;
    @(posedge i_mclk);
    #1;
    o_wr_stb = 1'b0;
    release_bus();
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d  = 8'h00;
    @(posedge i_mclk);
    #1;
    o_rd_stb = 1'b1;
    o_addr   = a;
    @(posedge i_mclk);
    #1;
    o_rd_stb = 1'b0;
    release_bus();
    for (int n = 0; n < 3 && !ok; n++) begin
      if (i_rd_valid === 1'b1) begin
        d  = i_rdata;
        ok = 1'b1;
      end else begin
        @(posedge i_mclk);
        #1;
      end
    end
  endtask
endmodule

// ### tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic       i_mclk, i_rst, undervoltage_lockout, sel, pf, lb;
  logic [3:0] pins;
  logic [2:0] ev, slew;
  logic [4:0] below;
  wire  [4:0] on_vec, code;
  wire  [7:0] cv, rdata, addr, wdata;
  wire  [2:0] dis;
  wire        wr, rd, rv, int_n, use_pin;
  int         err_total, check_count;

  pcr_regs dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_wr_stb(wr), .i_rd_stb(rd),
    .i_addr(addr), .i_wdata(wdata), .i_undervoltage_lockout(undervoltage_lockout),
    .i_buck1_enable_pin(pins[3]), .i_buck2_enable_pin(pins[2]),
    .i_buck3_enable_pin(pins[1]), .i_ldo_enable_pin(pins[0]),
    .i_core_default_select_pin(sel), .i_warm_reset_input_n(~ev[0]),
    .i_power_on_reset_out(ev[1]), .i_rtc_supply_low(ev[2]), .i_power_fail_flag(pf),
    .i_low_battery_flag(lb), .i_below_target(below), .i_core_slew_setting(slew),
    .o_rdata(rdata), .o_rd_valid(rv), .o_int_n(int_n), .o_buck1_on(on_vec[4]),
    .o_buck2_on(on_vec[3]), .o_buck3_on(on_vec[2]), .o_ldo2_on(on_vec[1]),
    .o_ldo1_on(on_vec[0]), .o_buck2_phase(cv[7:6]), .o_buck3_phase(cv[5:4]),
    .o_low_ripple(cv[3]), .o_buck2_forced_fixed_freq(cv[2]),
    .o_buck1_forced_fixed_freq(cv[1]), .o_buck3_forced_fixed_freq(cv[0]),
    .o_buck1_discharge(dis[2]), .o_buck2_discharge(dis[1]), .o_buck3_discharge(dis[0]),
    .o_core_use_pin(use_pin), .o_core_voltage_code(code));

  pcr_host host (.i_mclk(i_mclk), .i_rdata(rdata), .i_rd_valid(rv), .o_wr_stb(wr),
    .o_rd_stb(rd), .o_addr(addr), .o_wdata(wdata));

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  task automatic complete_run();
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host.read_reg(a, d, ok);
    if (!ok) begin
      err_total++;
      $display("mismatch at %0t: no read answer", $time);
      complete_run();
    end else begin
      chk(d, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  initial begin
    logic [7:0] rst_val [5];
    logic [7:0] cvv [2];
    rst_val = '{8'hc0, 8'hff, 8'hb1, 8'h40, 8'h14};
    cvv = '{8'he6, 8'h1d};
    i_rst = 1'b1;
    undervoltage_lockout = 1'b0;
    sel = 1'b0;
    pf = 1'b0;
    lb = 1'b0;
    pins = 4'hf;
    ev = 3'h0;
    slew = 3'h6;
    below = 5'h00;
    err_total = 0;
    check_count = 0;
    repeat (12) @(posedge i_mclk);
    #1;
    i_rst = 1'b0;
    cyc(2);
    chk({3'h0, on_vec}, 8'h1f);
    for (int k = 0; k < 5; k++) begin
      rd_chk(8'h02 + 8'(k), rst_val[k]);
    end
    rd_chk(8'h09, 8'hff);
    // Two settings together cover two codes of each phase field and both levels of mode bits 3, 1 and 0.
    for (int k = 0; k < 2; k++) begin
      host.write_reg(8'h04, cvv[k]);
      cyc(2);
      chk(cv, cvv[k]);
      rd_chk(8'h04, cvv[k]);
    end
    host.write_reg(8'h03, 8'h00);
    cyc(2);
    chk({3'h0, on_vec}, 8'h00);
    rd_chk(8'h03, 8'hc1);
    pins = 4'h6;
    cyc(2);
    pins = 4'hf;
    cyc(2);
    rd_chk(8'h03, 8'he7);
    chk({3'h0, on_vec}, 8'h13);
    host.write_reg(8'h05, 8'h3f);
    cyc(2);
    chk({4'h0, use_pin, dis}, 8'h03);
    rd_chk(8'h05, 8'h07);
    undervoltage_lockout = 1'b1;
    cyc(2);
    undervoltage_lockout = 1'b0;
    cyc(2);
    for (int k = 0; k < 4; k++) begin
      rd_chk(8'h02 + 8'(k), rst_val[k]);
    end
    chk({7'h0, use_pin}, 8'h01);
    below = 5'h01;
    pf = 1'b1;
    lb = 1'b1;
    cyc(4);
    chk({7'h0, int_n}, 8'h00);
    host.write_reg(8'h02, 8'hc2);
    cyc(4);
    chk({7'h0, int_n}, 8'h01);
    host.write_reg(8'h02, 8'hc0);
    cyc(4);
    chk({7'h0, int_n}, 8'h00);
    rd_chk(8'h01, 8'hc2);
    cyc(4);
    chk({7'h0, int_n}, 8'h01);
    below = 5'h00;
    host.write_reg(8'h03, 8'hfd);
    below = 5'h01;
    cyc(3);
    rd_chk(8'h01, 8'hc0);
    below = 5'h00;
    pf = 1'b0;
    lb = 1'b0;
    host.write_reg(8'h03, 8'hff);
    host.write_reg(8'h06, 8'h15);
    cyc(2);
    chk({3'h0, code}, 8'h14);
    host.write_reg(8'h05, 8'h80);
    rd_chk(8'h05, 8'h80);
    for (int n = 0; n < 200 && code !== 5'h15; n++) cyc(1);
    chk({3'h0, code}, 8'h15);
    cyc(2);
    rd_chk(8'h05, 8'h00);
    for (int k = 0; k < 3; k++) begin
      host.write_reg(8'h06, 8'h03);
      ev[k] = 1'b1;
      cyc(2);
      ev = 3'h0;
      cyc(2);
      rd_chk(8'h06, 8'h14);
    end
    sel = 1'b1;
    ev = 3'h1;
    cyc(2);
    ev = 3'h0;
    cyc(2);
    rd_chk(8'h06, 8'h1e);
    complete_run();
  end
endmodule
